// *** common/pst_pkg.sv ***
// Constants and types shared by the pixel sync and trigger port
package pst_pkg;
    // Core clock and the example pixel rate used for the default divider
    localparam int unsigned CORE_CLK_HZ    = 250_000_000;
    localparam int unsigned EX_PIX_RATE_HZ = 10_000;
    localparam int unsigned EX_HALF_NS     = 50_000; // Half period, 10 kHz
    // Core cycles per pixel clock half; rounded down, at least one cycle
    localparam int unsigned EX_HALF_CYC    =
        (CORE_CLK_HZ / (2 * EX_PIX_RATE_HZ)) > 0 ?
        (CORE_CLK_HZ / (2 * EX_PIX_RATE_HZ)) : 1;
    // Shortest trigger input pulse that must be caught
    localparam int unsigned TRIG_IN_MIN_NS = 50;

    // Port and counter widths
    localparam int N_TRIG_IN  = 4;
    localparam int N_SYNC_OUT = 8;
    localparam int N_SW_TRIG  = 4;
    localparam int CNT_W      = 12;
    localparam int HALF_W     = 16;

    // Pixels between the sync pulses and the first image pixel
    localparam int unsigned LEAD_PIX = 16;
    localparam logic [CNT_W-1:0] LEAD_LAST = CNT_W'(LEAD_PIX - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 12'h001;
    localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;
    localparam logic [HALF_W-1:0] HALF_ONE  = 16'h0001;

    // Bit positions in the synchronous output group
    localparam int OUT_SW_LSB = 0;
    localparam int OUT_STACK  = 4;
    localparam int OUT_GRAB   = 5;
    localparam int OUT_LINE   = 6;
    localparam int OUT_FRAME  = 7;

    // Line sequencer states
    typedef enum logic [1:0] {
        PST_IDLE,
        PST_LEAD,
        PST_GRAB,
        PST_GAP
    } pst_seq_t;
endpackage

// *** design/pst_port.sv ***
// Pixel clock, sync pulses, trigger outputs and trigger input interrupts
module pst_port #(
    parameter int unsigned PIX_HALF_CYC = pst_pkg::EX_HALF_CYC
) (
    input  wire logic                           core_clk,
    input  wire logic                           nrst,
    input  wire logic                           clk_en,
    input  wire logic                           acq_run,
    input  wire logic                           zstack_en,
    input  wire logic [pst_pkg::CNT_W-1:0]      line_pixels,
    input  wire logic [pst_pkg::CNT_W-1:0]      gap_pixels,
    input  wire logic [pst_pkg::CNT_W-1:0]      frame_lines,
    input  wire logic [pst_pkg::CNT_W-1:0]      stack_frames,
    input  wire logic [pst_pkg::N_SW_TRIG-1:0]  sw_trig_req,
    input  wire logic                           link_clk,
    input  wire logic [pst_pkg::N_TRIG_IN-1:0]  external_trigger_input,
    output logic                                pix_clk_out,
    output logic [pst_pkg::N_SYNC_OUT-1:0]      sync_out,
    output logic [pst_pkg::N_TRIG_IN-1:0]       trig_irq
);
    import pst_pkg::*;

    localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(PIX_HALF_CYC - 1);

    // ---------------- Pixel clock divider ----------------
    logic [HALF_W-1:0] half_cnt_q, half_cnt_d;
    logic              pclk_q, pclk_d;
    logic              tick;

    // Toggle every half period; tick marks the rising edge of a pixel
    always_comb begin
        half_cnt_d = half_cnt_q;
        pclk_d     = pclk_q;
        tick       = 1'b0;
        if (clk_en) begin
            if (half_cnt_q == HALF_LAST) begin
                half_cnt_d = HALF_ZERO;
                pclk_d     = ~pclk_q;
                tick       = ~pclk_q;
            end else begin
                half_cnt_d = half_cnt_q + HALF_ONE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            half_cnt_q <= HALF_ZERO;
            pclk_q     <= 1'b0;
        end else begin
            half_cnt_q <= half_cnt_d;
            pclk_q     <= pclk_d;
        end
    end

    // ---------------- Line sequencer ----------------
    pst_seq_t          st_q, st_d;
    logic [CNT_W-1:0]  pcnt_q, pcnt_d;
    logic [CNT_W-1:0]  line_q, line_d;
    logic [CNT_W-1:0]  frame_q, frame_d;
    logic              lead_start;
    logic              line_wrap;
    logic [CNT_W-1:0]  grab_last;

    // A zero length line still captures one pixel
    assign grab_last = (line_pixels == CNT_ZERO) ? CNT_ZERO
                                                 : line_pixels - CNT_ONE;
    assign line_wrap = (line_q + CNT_ONE >= frame_lines);

    // Advances once per pixel; of the sync pulses only the stack pulse can be muted, by zstack_en
    always_comb begin
        st_d       = st_q;
        pcnt_d     = pcnt_q;
        line_d     = line_q;
        frame_d    = frame_q;
        lead_start = 1'b0;
        if (tick) begin
            case (st_q)
                PST_IDLE: begin
                    line_d  = CNT_ZERO;
                    frame_d = CNT_ZERO;
                    if (acq_run) begin
                        st_d       = PST_LEAD;
                        pcnt_d     = LEAD_LAST;
                        lead_start = 1'b1;
                    end
                end
                PST_LEAD: begin
                    if (pcnt_q == CNT_ZERO) begin
                        st_d   = PST_GRAB;
                        pcnt_d = grab_last;
                    end else begin
                        pcnt_d = pcnt_q - CNT_ONE;
                    end
                end
                PST_GRAB: begin
                    if (pcnt_q == CNT_ZERO) begin
                        st_d   = PST_GAP;
                        pcnt_d = gap_pixels;
                    end else begin
                        pcnt_d = pcnt_q - CNT_ONE;
                    end
                end
                PST_GAP: begin
                    if (pcnt_q == CNT_ZERO) begin
                        // Line counter steps after each line; frame counter only after a frame's last line
                        if (line_wrap) begin
                            line_d = CNT_ZERO;
                            if (frame_q + CNT_ONE >= stack_frames) begin
                                frame_d = CNT_ZERO;
                            end else begin
                                frame_d = frame_q + CNT_ONE;
                            end
                        end else begin
                            line_d = line_q + CNT_ONE;
                        end
                        if (acq_run) begin
                            st_d       = PST_LEAD;
                            pcnt_d     = LEAD_LAST;
                            lead_start = 1'b1;
                        end else begin
                            st_d = PST_IDLE;
                        end
                    end else begin
                        pcnt_d = pcnt_q - CNT_ONE;
                    end
                end
                default: begin
                    st_d = PST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q    <= PST_IDLE;
            pcnt_q  <= CNT_ZERO;
            line_q  <= CNT_ZERO;
            frame_q <= CNT_ZERO;
        end else begin
            st_q    <= st_d;
            pcnt_q  <= pcnt_d;
            line_q  <= line_d;
            frame_q <= frame_d;
        end
    end

    // ---------------- Output group ----------------
    logic [N_SW_TRIG-1:0]  pend_q, pend_d;
    logic [N_SYNC_OUT-1:0] out_q, out_d;
    logic                  first_line;

    // Counters hold the line about to be led in
    assign first_line = (line_d == CNT_ZERO);

    // Requests wait for the next pixel edge, so every pulse but grabbing is one pixel
    always_comb begin
        pend_d = pend_q;
        out_d  = out_q;
        if (clk_en) begin
            pend_d = pend_q | sw_trig_req;
            if (tick) begin
                out_d[OUT_SW_LSB +: N_SW_TRIG] = pend_q | sw_trig_req;
                pend_d           = '0;
                out_d[OUT_LINE]  = lead_start;
                out_d[OUT_FRAME] = lead_start & first_line;
                out_d[OUT_STACK] = lead_start & first_line & zstack_en
                                   & (frame_d == CNT_ZERO);
                out_d[OUT_GRAB]  = (st_d == PST_GRAB);
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pend_q <= '0;
            out_q  <= '0;
        end else begin
            pend_q <= pend_d;
            out_q  <= out_d;
        end
    end

    assign pix_clk_out = pclk_q;
    assign sync_out    = out_q;

    // ---------------- Trigger inputs, link domain ----------------
    // Pins land on the link clock; 12 ns sampling catches any pulse
    // longer than the minimum width
    logic [N_TRIG_IN-1:0] lk_s1_q, lk_s2_q, lk_s3_q, lk_tgl_q;
    logic [N_TRIG_IN-1:0] lk_s1_d, lk_s2_d, lk_s3_d, lk_tgl_d;

    always_comb begin
        lk_s1_d  = external_trigger_input;
        lk_s2_d  = lk_s1_q;
        lk_s3_d  = lk_s2_q;
        // Falling edge flips a toggle that carries the event across
        lk_tgl_d = lk_tgl_q ^ (lk_s3_q & ~lk_s2_q);
    end

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            lk_s1_q  <= '1;
            lk_s2_q  <= '1;
            lk_s3_q  <= '1;
            lk_tgl_q <= '0;
        end else begin
            lk_s1_q  <= lk_s1_d;
            lk_s2_q  <= lk_s2_d;
            lk_s3_q  <= lk_s3_d;
            lk_tgl_q <= lk_tgl_d;
        end
    end

    // ---------------- Trigger interrupts, core domain ----------------
    logic [N_TRIG_IN-1:0] c_s1_q, c_s2_q, c_s3_q, irq_q;
    logic [N_TRIG_IN-1:0] c_s1_d, c_s2_d, c_s3_d, irq_d;

    // A toggle change becomes a one cycle interrupt pulse per input
    always_comb begin
        c_s1_d = c_s1_q;
        c_s2_d = c_s2_q;
        c_s3_d = c_s3_q;
        irq_d  = irq_q;
        if (clk_en) begin
            c_s1_d = lk_tgl_q;
            c_s2_d = c_s1_q;
            c_s3_d = c_s2_q;
            irq_d  = c_s2_q ^ c_s3_q;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            c_s1_q <= '0;
            c_s2_q <= '0;
            c_s3_q <= '0;
            irq_q  <= '0;
        end else begin
            c_s1_q <= c_s1_d;
            c_s2_q <= c_s2_d;
            c_s3_q <= c_s3_d;
            irq_q  <= irq_d;
        end
    end

    // Series and bleach actions are decoded by firmware from these
    assign trig_irq = irq_q;
endmodule

// *** verif/pst_port_monitor.sv ***
// Timing checker for the pixel clock, sync outputs and trigger interrupts
module pst_port_monitor #(
    parameter int unsigned PIX_HALF_CYC = 4
) (
    input wire logic                           core_clk,
    input wire logic                           nrst,
    input wire logic                           clk_en,
    input wire logic [pst_pkg::CNT_W-1:0]      line_pixels,
    input wire logic [pst_pkg::N_TRIG_IN-1:0]  external_trigger_input,
    input wire logic                           pix_clk_out,
    input wire logic [pst_pkg::N_SYNC_OUT-1:0] sync_out,
    input wire logic [pst_pkg::N_TRIG_IN-1:0]  trig_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import pst_pkg::*;
    logic [15:0] grab_q;
    logic [15:0] grab_d;
    default clocking cb @(posedge core_clk); endclocking
    // A frozen clock enable stretches every timed window, so pause them
    default disable iff (!nrst || !clk_en);
    // Cycles the grabbing output has stood high
    always_comb begin
        grab_d = sync_out[OUT_GRAB] ? grab_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) grab_q <= 16'h0000;
        else grab_q <= grab_d;
    end
    // Repeat counts assume a half of four cycles, as the bench builds it
    sequence s_hold_high;
        pix_clk_out[*3] ##1 !pix_clk_out;
    endsequence
    sequence s_hold_low;
        !pix_clk_out[*3] ##1 pix_clk_out;
    endsequence
    a_pix_high_half: assert property ($rose(pix_clk_out) |=> s_hold_high)
        else $error("pixel clock high half has wrong length");
    a_pix_low_half: assert property ($fell(pix_clk_out) |=> s_hold_low)
        else $error("pixel clock low half has wrong length");
    a_line_one_pixel: assert property ($rose(sync_out[OUT_LINE]) |=>
        sync_out[OUT_LINE][*7] ##1 !sync_out[OUT_LINE])
        else $error("line pulse is not one pixel long");
    a_sw_one_pixel: assert property ($rose(sync_out[OUT_SW_LSB]) |=>
        sync_out[OUT_SW_LSB][*7])
        else $error("trigger pulse shorter than one pixel");
    a_out_on_tick: assert property ((|(sync_out & ~$past(sync_out))) |->
        $rose(pix_clk_out))
        else $error("output rose off the pixel clock edge");
    a_lead_sixteen: assert property ($rose(sync_out[OUT_LINE]) |->
        ##128 $rose(sync_out[OUT_GRAB]))
        else $error("grabbing did not start sixteen pixels after line");
    a_frame_with_line: assert property ((sync_out[OUT_FRAME] ||
        sync_out[OUT_STACK]) |-> sync_out[OUT_LINE])
        else $error("frame or stack pulse without line pulse");
    a_grab_span: assert property ($fell(sync_out[OUT_GRAB]) |->
        grab_q == 2 * PIX_HALF_CYC * line_pixels)
        else $error("grabbing length differs from line pixels");
    a_irq_after_fall: assert property ($fell(external_trigger_input[0]) |->
        ##[4:40] trig_irq[0])
        else $error("no interrupt after falling trigger input");
    a_irq_one_cycle: assert property (trig_irq[0] |=> !trig_irq[0])
        else $error("interrupt pulse longer than one cycle");
    a_en_freeze: assert property (disable iff (!nrst) !clk_en |=>
        $stable(pix_clk_out) && $stable(sync_out) && $stable(trig_irq))
        else $error("outputs moved while the clock enable was low");
endmodule

bind pst_port pst_port_monitor #(.PIX_HALF_CYC(PIX_HALF_CYC)) u_mon (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .line_pixels(line_pixels),
    .external_trigger_input(external_trigger_input),
    .pix_clk_out(pix_clk_out), .sync_out(sync_out), .trig_irq(trig_irq));

// *** verif/pst_ext_src.sv ***
// Pulse generator model driving the four trigger input pins
module pst_ext_src (
    input  wire logic                          link_clk,
    input  wire logic [pst_pkg::N_TRIG_IN-1:0] fire,
    output logic [pst_pkg::N_TRIG_IN-1:0]      pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import pst_pkg::*;
    int cnt [N_TRIG_IN];
    // Pins idle high through the pull-up
    initial pins = 4'hF;
    // Each request pulls its pin low for eight link clocks, well over 50 ns
    always @(posedge link_clk) begin
        for (int i = 0; i < N_TRIG_IN; i++) begin
            if (cnt[i] == 0 && fire[i]) cnt[i] = 8;
            else if (cnt[i] > 0) cnt[i] = cnt[i] - 1;
            pins[i] <= (cnt[i] == 0);
        end
    end
endmodule

// *** verif/pst_port_tb_top.sv ***
// Self-checking bench for the pixel sync and trigger port
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t value mismatch", $time); end end
module pst_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pst_pkg::*;
    localparam int unsigned HC = 4;
    localparam int PIX = 2 * HC;
    logic             core_clk = 1'b0;
    logic             link_clk = 1'b0;
    logic             nrst = 1'b0;
    logic             clk_en = 1'b1;
    logic             acq_run = 1'b0;
    logic             zstack_en = 1'b0;
    logic [CNT_W-1:0] line_pixels = 12'h003;
    logic [CNT_W-1:0] gap_pixels = 12'h001;
    logic [CNT_W-1:0] frame_lines = 12'h002;
    logic [CNT_W-1:0] stack_frames = 12'h002;
    logic [3:0]       sw_trig_req = 4'h0;
    logic [3:0]       fire = 4'h0;
    logic [3:0]       ext_pins;
    logic             pix_clk_out;
    logic [7:0]       sync_out;
    logic [3:0]       trig_irq;
    logic [12:0]      obs;
    int               miscompares = 0;
    int               compares = 0;
    int               n;
    assign obs = {trig_irq, pix_clk_out, sync_out};
    always #2 core_clk = ~core_clk;
    // Link clock offset so its edges never line up with the core clock
    initial #3 forever #6 link_clk = ~link_clk;
    pst_port #(.PIX_HALF_CYC(HC)) dut (.core_clk(core_clk), .nrst(nrst),
        .clk_en(clk_en), .acq_run(acq_run), .zstack_en(zstack_en),
        .line_pixels(line_pixels), .gap_pixels(gap_pixels),
        .frame_lines(frame_lines), .stack_frames(stack_frames),
        .sw_trig_req(sw_trig_req), .link_clk(link_clk),
        .external_trigger_input(ext_pins), .pix_clk_out(pix_clk_out),
        .sync_out(sync_out), .trig_irq(trig_irq));
    pst_ext_src u_src (.link_clk(link_clk), .fire(fire), .pins(ext_pins));
    task automatic print_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Bounded wait for a watched output; a hang ends the run
    task automatic wait_hi(input int b);
        int k;
        k = 0;
        while (obs[b] !== 1'b1 && k < 400) begin
            @(negedge core_clk);
            k++;
        end
        if (k == 400) begin
            miscompares++;
            print_verdict();
        end
    endtask
    // Cycles a watched output stays high
    task automatic len_hi(input int b, output int c);
        c = 0;
        while (obs[b] === 1'b1 && c < 400) begin
            @(negedge core_clk);
            c++;
        end
        if (c == 400) begin
            miscompares++;
            print_verdict();
        end
    endtask
    // Clock enable low must freeze the pixel clock and the sync outputs
    task automatic t_en();
        logic       p;
        logic [7:0] s;
        p = pix_clk_out;
        s = sync_out;
        clk_en = 1'b0;
        repeat (20) @(negedge core_clk);
        `CHK(pix_clk_out, p)
        `CHK(sync_out, s)
        clk_en = 1'b1;
        len_hi(8, n);
        wait_hi(8);
        len_hi(8, n);
        `CHK(n, HC)
        $display("test clock enable done");
    endtask
    task automatic t_pix();
        wait_hi(8);
        len_hi(8, n);
        `CHK(n, HC)
        $display("test pixel clock done");
    endtask
    task automatic t_sw();
        for (int i = 0; i < N_SW_TRIG; i++) begin
            sw_trig_req[i] = 1'b1;
            @(negedge core_clk);
            sw_trig_req[i] = 1'b0;
            wait_hi(OUT_SW_LSB + i);
            `CHK(pix_clk_out, 1'b1)
            len_hi(OUT_SW_LSB + i, n);
            `CHK(n, PIX)
        end
        $display("test software triggers done");
    endtask
    task automatic t_line();
        zstack_en = 1'b1;
        acq_run = 1'b1;
        wait_hi(OUT_LINE);
        `CHK(sync_out[OUT_FRAME], 1'b1)
        `CHK(sync_out[OUT_STACK], 1'b1)
        len_hi(OUT_LINE, n);
        `CHK(n, PIX)
        wait_hi(OUT_GRAB);
        len_hi(OUT_GRAB, n);
        `CHK(n, 3 * PIX)
        wait_hi(OUT_LINE);
        `CHK(sync_out[OUT_FRAME], 1'b0)
        acq_run = 1'b0;
        $display("test line sequence done");
    endtask
    task automatic t_irq();
        for (int i = 0; i < N_TRIG_IN; i++) begin
            fire[i] = 1'b1;
            repeat (4) @(negedge core_clk);
            fire[i] = 1'b0;
            wait_hi(9 + i);
            `CHK(trig_irq, 4'h1 << i)
            len_hi(9 + i, n);
            `CHK(n, 1)
            repeat (40) @(negedge core_clk);
        end
        $display("test trigger inputs done");
    endtask
    initial begin
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        t_pix();
        t_sw();
        t_line();
        t_irq();
        t_en();
        print_verdict();
    end
endmodule
